// *** asp_pkg.sv ***
// asp_pkg: constants, states and carrier types for the static memory port
// assumes a 125 MHz system clock; figures are for the fastest speed grade
package asp_pkg;

  localparam int ASP_ADDR_W   = 15;
  localparam int ASP_DATA_W   = 8;
  localparam int ASP_CLK_PS   = 8000;

  // ==========================================================================
  // timing figures, picoseconds
  localparam int ASP_T_READ_CYCLE_PS = 20000;
  localparam int ASP_T_INDEX_ACC_PS  = 20000;
  localparam int ASP_T_GATE_VALID_PS = 10000;
  localparam int ASP_T_OUT_HOLD_PS   = 5000;
  localparam int ASP_T_WRITE_CYC_PS  = 20000;
  localparam int ASP_T_SEL_END_PS    = 15000;
  localparam int ASP_T_IDX_END_PS    = 15000;
  localparam int ASP_T_MIN_PULSE_PS  = 15000;
  localparam int ASP_T_DATA_SETUP_PS = 11000;
  localparam int ASP_T_DATA_HOLD_PS  = 0;
  localparam int ASP_T_RECOVERY_PS   = 0;
  localparam int ASP_T_STROBE_FLT_PS = 10000;
  localparam int ASP_T_OUT_ACT_PS    = 5000;
  localparam int ASP_T_DESEL_FLT_PS  = 10000;
  localparam int ASP_T_RETENTION_PS  = 20000;

  // least times round up, never below one cycle
  function automatic int asp_up(input int ps);
    int n;
    n = (ps + ASP_CLK_PS - 1) / ASP_CLK_PS;
    return (n < 1) ? 1 : n;
  endfunction

  function automatic int asp_max(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  localparam int ASP_PULSE_PS = asp_max(asp_max(ASP_T_MIN_PULSE_PS,
    ASP_T_SEL_END_PS), asp_max(ASP_T_IDX_END_PS,
    ASP_T_STROBE_FLT_PS + ASP_T_OUT_ACT_PS));
  localparam int ASP_RD_CYC   = asp_up(asp_max(ASP_T_READ_CYCLE_PS,
    asp_max(ASP_T_INDEX_ACC_PS, ASP_T_GATE_VALID_PS)));
  localparam int ASP_WR_PULSE = asp_up(asp_max(ASP_PULSE_PS,
    ASP_T_DATA_SETUP_PS));
  localparam int ASP_WR_CYC   = asp_up(ASP_T_WRITE_CYC_PS);
  localparam int ASP_WR_TAIL  = asp_max(asp_up(ASP_T_RECOVERY_PS),
    asp_max(ASP_WR_CYC - ASP_WR_PULSE, 1));
  localparam int ASP_FLOAT    = asp_up(ASP_T_DESEL_FLT_PS);
  localparam int ASP_RET_CYC  = asp_up(ASP_T_RETENTION_PS);
  localparam int ASP_CNT_W    = 8;

  localparam logic [ASP_CNT_W-1:0] ASP_CNT_ZERO = 8'h00;
  localparam logic [ASP_CNT_W-1:0] ASP_CNT_ONE  = 8'h01;

  typedef enum logic [2:0] {
    ASP_ST_WAKE   = 3'b000,
    ASP_ST_IDLE   = 3'b001,
    ASP_ST_READ   = 3'b010,
    ASP_ST_WRITE  = 3'b011,
    ASP_ST_WTAIL  = 3'b100,
    ASP_ST_FLOAT  = 3'b101
  } asp_state_t;

  typedef struct packed {
    logic                  write;
    logic [ASP_ADDR_W-1:0] addr;
    logic [ASP_DATA_W-1:0] data;
  } asp_req_t;

  typedef struct packed {
    logic                  select_n;
    logic                  strobe_n;
    logic                  gate_n;
    logic [ASP_ADDR_W-1:0] word_index_lines;
    logic [ASP_DATA_W-1:0] bus_out;
    logic                  bus_oe;
  } asp_pins_t;

endpackage

// *** asp_countdown.sv ***
// asp_countdown: loadable down counter that flags its last cycle
// assumes one clock domain; load wins over counting
`timescale 1ns/1ps
`default_nettype none
module asp_countdown
  import asp_pkg::*;
#(
  parameter int W = ASP_CNT_W
) (
  input  wire logic         sys_clk,   // system clock
  input  wire logic         resetn,    // async reset, active low
  input  wire logic         load,      // load a new count
  input  wire logic [W-1:0] value,     // count to load
  output logic              done       // count is at its last cycle
);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (load) begin
      cnt_next = value;
    end else if (cnt_reg != ASP_CNT_ZERO) begin
      cnt_next = cnt_reg - ASP_CNT_ONE;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= ASP_CNT_ZERO;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign done = (cnt_reg <= ASP_CNT_ONE);

endmodule
`default_nettype wire

// *** asp_ctrl.sv ***
// asp_ctrl: synchronous controller for a 32K x 8 asynchronous static memory
// assumes requests from logic on sys_clk; the memory pins are off-chip
//
// Function
// - address changes only while select and write strobe are both high.
// - write recovery from first rising strobe; zero minimum, one cycle kept.
// - data bus driven only while the memory cannot drive it.
// - strobe low covers write pulse, float-plus-active time; gate stays high.
// - select-timed writes may keep the gate low; this design keeps it high.
// - write strobe held high throughout every read cycle.
// - write cycle at least 20 ns; select and index lead write end 15 ns.
// - write data valid 11 ns before write end, removed at or after it.
// - after supply recovery wait one read cycle time before any access.
`timescale 1ns/1ps
`default_nettype none
module asp_ctrl
  import asp_pkg::*;
#(
  parameter int AW = ASP_ADDR_W,
  parameter int DW = ASP_DATA_W
) (
  input  wire logic          sys_clk,          // system clock
  input  wire logic          resetn,           // async reset, active low
  input  wire logic          supply_ok,        // memory supply at full level
  input  wire logic          req_valid,        // request offered
  input  wire logic          req_write,        // 1 write, 0 read
  input  wire logic [AW-1:0] req_addr,         // byte index
  input  wire logic [DW-1:0] req_wdata,        // write data
  output logic               req_ready,        // request taken when valid
  output logic               rsp_valid,        // read data or write done pulse
  output logic [DW-1:0]      rsp_rdata,        // read data
  output logic [AW-1:0]      word_index_lines, // memory index pins
  output logic               select_n,         // memory select, active low
  output logic               strobe_n,         // write strobe, active low
  output logic               gate_n,           // output gate, active low
  output logic [DW-1:0]      shared_byte_bus_o,  // bus drive value
  output logic               shared_byte_bus_oe, // bus drive enable
  input  wire logic [DW-1:0] shared_byte_bus_i   // bus level from pins
);

  // ==========================================================================
  // state and pin registers
  asp_state_t      state_reg,  state_next;
  logic [AW-1:0]   addr_reg,   addr_next;
  logic [DW-1:0]   wdata_reg,  wdata_next;
  logic [DW-1:0]   rdata_reg,  rdata_next;
  logic            sel_reg,    sel_next;
  logic            stb_reg,    stb_next;
  logic            gate_reg,   gate_next;
  logic            oe_reg,     oe_next;
  logic            rdy_reg,    rdy_next;
  logic            rsp_reg,    rsp_next;
  logic            load;
  logic [ASP_CNT_W-1:0] load_val;
  logic            cnt_done;

  // ==========================================================================
  // supply level synchroniser: three stages, second and third must agree
  logic [2:0] sup_sync_reg;
  logic [2:0] sup_sync_next;
  logic       sup_good_reg;
  logic       sup_good_next;
  logic       sup_rise;

  always_comb begin
    sup_sync_next = {sup_sync_reg[1:0], supply_ok};
    sup_good_next = sup_good_reg;
    if (sup_sync_reg[1] == sup_sync_reg[2]) begin
      sup_good_next = sup_sync_reg[2];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sup_sync_reg <= 3'h0;
      sup_good_reg <= 1'b0;
    end else begin
      sup_sync_reg <= sup_sync_next;
      sup_good_reg <= sup_good_next;
    end
  end

  assign sup_rise = sup_good_next & ~sup_good_reg;

  // ==========================================================================
  // interval counter
  asp_countdown #(
    .W (ASP_CNT_W)
  ) u_cnt (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .load    (load),
    .value   (load_val),
    .done    (cnt_done)
  );

  // ==========================================================================
  // sequencer
  always_comb begin
    state_next = state_reg;
    addr_next  = addr_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    sel_next   = sel_reg;
    stb_next   = stb_reg;
    gate_next  = gate_reg;
    oe_next    = oe_reg;
    rdy_next   = 1'b0;
    rsp_next   = 1'b0;
    load       = 1'b0;
    load_val   = ASP_CNT_ZERO;
    unique case (state_reg)
      ASP_ST_WAKE: begin
        sel_next  = 1'b1;
        stb_next  = 1'b1;
        gate_next = 1'b1;
        oe_next   = 1'b0;
        if (sup_rise) begin
          load     = 1'b1;
          load_val = ASP_CNT_W'(ASP_RET_CYC);
        end else if (sup_good_reg && cnt_done) begin
          state_next = ASP_ST_IDLE;
          rdy_next   = sup_good_next;
        end
      end
      ASP_ST_IDLE: begin
        // ready follows the synchronised supply so no offer is lost
        rdy_next = sup_good_next;
        if (!sup_good_reg) begin
          state_next = ASP_ST_WAKE;
          rdy_next   = 1'b0;
        end else if (req_valid && rdy_reg) begin
          // index moves only while both strobes are high
          addr_next = req_addr;
          rdy_next  = 1'b0;
          sel_next  = 1'b0;
          load      = 1'b1;
          if (req_write) begin
            wdata_next = req_wdata;
            stb_next   = 1'b0;
            gate_next  = 1'b1;
            oe_next    = 1'b1;
            load_val   = ASP_CNT_W'(ASP_WR_PULSE);
            state_next = ASP_ST_WRITE;
          end else begin
            stb_next   = 1'b1;
            gate_next  = 1'b0;
            oe_next    = 1'b0;
            load_val   = ASP_CNT_W'(ASP_RD_CYC);
            state_next = ASP_ST_READ;
          end
        end
      end
      ASP_ST_READ: begin
        if (cnt_done) begin
          // capture while index is still stable
          rdata_next = shared_byte_bus_i;
          rsp_next   = 1'b1;
          sel_next   = 1'b1;
          gate_next  = 1'b1;
          load       = 1'b1;
          load_val   = ASP_CNT_W'(ASP_FLOAT);
          state_next = ASP_ST_FLOAT;
        end
      end
      ASP_ST_WRITE: begin
        if (cnt_done) begin
          // both rise together; data and index held one more cycle
          sel_next   = 1'b1;
          stb_next   = 1'b1;
          rsp_next   = 1'b1;
          load       = 1'b1;
          load_val   = ASP_CNT_W'(ASP_WR_TAIL);
          state_next = ASP_ST_WTAIL;
        end
      end
      ASP_ST_WTAIL: begin
        if (cnt_done) begin
          oe_next    = 1'b0;
          state_next = ASP_ST_IDLE;
          rdy_next   = sup_good_next;
        end
      end
      ASP_ST_FLOAT: begin
        // memory may still drive until deselect float time passes
        if (cnt_done) begin
          state_next = ASP_ST_IDLE;
          rdy_next   = sup_good_next;
        end
      end
      default: begin
        state_next = ASP_ST_WAKE;
        sel_next   = 1'b1;
        stb_next   = 1'b1;
        gate_next  = 1'b1;
        oe_next    = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ASP_ST_WAKE;
      addr_reg  <= '0;
      wdata_reg <= '0;
      rdata_reg <= '0;
      sel_reg   <= 1'b1;
      stb_reg   <= 1'b1;
      gate_reg  <= 1'b1;
      oe_reg    <= 1'b0;
      rdy_reg   <= 1'b0;
      rsp_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      addr_reg  <= addr_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      sel_reg   <= sel_next;
      stb_reg   <= stb_next;
      gate_reg  <= gate_next;
      oe_reg    <= oe_next;
      rdy_reg   <= rdy_next;
      rsp_reg   <= rsp_next;
    end
  end

  // ==========================================================================
  // outputs straight from registers
  assign req_ready          = rdy_reg;
  assign rsp_valid          = rsp_reg;
  assign rsp_rdata          = rdata_reg;
  assign word_index_lines   = addr_reg;
  assign select_n           = sel_reg;
  assign strobe_n           = stb_reg;
  assign gate_n             = gate_reg;
  assign shared_byte_bus_o  = wdata_reg;
  assign shared_byte_bus_oe = oe_reg;

endmodule
`default_nettype wire

// *** asp_ctrl_props.sv ***
// asp_ctrl_props: pin timing checks for the static memory controller
// assumes binding to asp_ctrl; one clock domain
`timescale 1ns/1ps
`default_nettype none
module asp_ctrl_props
  import asp_pkg::*;
#(
  parameter int AW = ASP_ADDR_W,
  parameter int DW = ASP_DATA_W
) (
  input wire logic          sys_clk,            // system clock
  input wire logic          resetn,             // async reset
  input wire logic          req_ready,          // request accepted
  input wire logic          rsp_valid,          // response pulse
  input wire logic [AW-1:0] word_index_lines,   // memory index
  input wire logic          select_n,           // select
  input wire logic          strobe_n,           // write strobe
  input wire logic          gate_n,             // output gate
  input wire logic [DW-1:0] shared_byte_bus_o,  // bus drive value
  input wire logic          shared_byte_bus_oe  // bus drive enable
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // ======
  // pulse shapes
  sequence s_wr_low;
    (!strobe_n && !select_n && shared_byte_bus_oe) [*2];
  endsequence
  sequence s_rd_low;
    (!gate_n && !select_n && strobe_n) [*3];
  endsequence
  a_index_move: assert property (
    !$stable(word_index_lines) |-> $past(select_n) && $past(strobe_n))
    else $error("index moved while selected");
  a_write_shape: assert property (
    $fell(strobe_n) |-> s_wr_low ##1 (strobe_n && select_n && rsp_valid))
    else $error("write pulse shape wrong");
  a_select_with: assert property (
    $fell(strobe_n) |-> $fell(select_n))
    else $error("select not falling with strobe");
  a_data_held: assert property (
    $fell(strobe_n) |=> $stable(shared_byte_bus_o) ##1 shared_byte_bus_oe)
    else $error("write data not held");
  a_write_gap: assert property (
    $rose(strobe_n) |=> !shared_byte_bus_oe && req_ready)
    else $error("write tail wrong");
  a_read_shape: assert property (
    $fell(gate_n) |-> s_rd_low ##1 (gate_n && select_n && rsp_valid))
    else $error("read pulse shape wrong");
  a_read_quiet: assert property (
    !gate_n |-> strobe_n && !shared_byte_bus_oe)
    else $error("drive or strobe during read");
  a_float_wait: assert property (
    $rose(gate_n) |-> (!req_ready && !shared_byte_bus_oe) [*2])
    else $error("no float gap after read");
  a_standby_quiet: assert property (
    select_n |-> strobe_n && gate_n)
    else $error("strobe or gate low while deselected");
endmodule
bind asp_ctrl asp_ctrl_props #(.AW(AW), .DW(DW)) u_asp_ctrl_props (
  .sys_clk(sys_clk), .resetn(resetn), .req_ready(req_ready),
  .rsp_valid(rsp_valid), .word_index_lines(word_index_lines),
  .select_n(select_n), .strobe_n(strobe_n), .gate_n(gate_n),
  .shared_byte_bus_o(shared_byte_bus_o),
  .shared_byte_bus_oe(shared_byte_bus_oe));
`default_nettype wire

// *** asp_mem_model.sv ***
// asp_mem_model: behavioural 32K x 8 static memory
// assumes pins from asp_ctrl; the bench resolves the shared bus
`timescale 1ns/1ps
`default_nettype none
module asp_mem_model
  import asp_pkg::*;
#(
  parameter int ACC_NS = 20  // access time, raise for a slow part
) (
  input  wire logic [ASP_ADDR_W-1:0] word_index_lines, // index pins
  input  wire logic                  select_n,         // select
  input  wire logic                  strobe_n,         // write strobe
  input  wire logic                  gate_n,           // output gate
  input  wire logic [ASP_DATA_W-1:0] bus_in,           // resolved bus
  output logic      [ASP_DATA_W-1:0] mem_out,          // drive value
  output logic                       mem_oe            // drive enable
);
  logic [ASP_DATA_W-1:0] mem [0:32767];
  logic [ASP_DATA_W-1:0] prev;
  logic                  wr_on;
  bit                    wr_act;
  realtime               t_chg;
  initial begin
    for (int i = 0; i < 32768; i++) mem[i] = i[7:0] ^ i[14:7];
    t_chg = 0;
    prev = 8'h00;
  end
  assign wr_on = !select_n && !strobe_n;
  // store at the end of the overlap
  // only a real end of overlap stores; the power-up settle does not
  always @(wr_on) begin
    if (wr_on === 1'b0 && wr_act) mem[word_index_lines] = bus_in;
    wr_act = (wr_on === 1'b1);
  end
  always @(word_index_lines or select_n or gate_n) begin
    prev = mem_out;
    t_chg = $realtime;
  end
  always #1 begin
    mem_oe = !select_n && !gate_n && strobe_n;
    if ($realtime - t_chg < 5) mem_out = prev;
    else if ($realtime - t_chg < ACC_NS) mem_out = ~mem[word_index_lines];
    else mem_out = mem[word_index_lines];
  end
endmodule
`default_nettype wire

// *** testbench.sv ***
// testbench: self-checking bench for asp_ctrl with a memory model
// assumes asp_pkg, asp_ctrl, asp_mem_model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import asp_pkg::*;
  logic                  sys_clk = 1'b0;
  logic                  resetn, supply_ok, req_valid, req_write;
  logic                  req_ready, rsp_valid, select_n, strobe_n, gate_n;
  logic                  bus_oe, mem_oe;
  logic [ASP_ADDR_W-1:0] req_addr, word_index_lines, a;
  logic [ASP_DATA_W-1:0] req_wdata, rsp_rdata, bus_o, bus, mem_out, flt, d;
  logic [ASP_DATA_W-1:0] shadow [0:32767];
  int                    err_count, num_checks, n;

  asp_ctrl u_asp_ctrl (.sys_clk(sys_clk), .resetn(resetn),
    .supply_ok(supply_ok), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .word_index_lines(word_index_lines), .select_n(select_n),
    .strobe_n(strobe_n), .gate_n(gate_n), .shared_byte_bus_o(bus_o),
    .shared_byte_bus_oe(bus_oe), .shared_byte_bus_i(bus));
  asp_mem_model u_asp_mem_model (.word_index_lines(word_index_lines),
    .select_n(select_n), .strobe_n(strobe_n), .gate_n(gate_n),
    .bus_in(bus), .mem_out(mem_out), .mem_oe(mem_oe));
  // undriven bus wanders every cycle
  assign bus = bus_oe ? bus_o : ((mem_oe === 1'b1) ? mem_out : flt);
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) flt <= resetn ? flt + 8'h3D : 8'h00;

  function automatic logic [7:0] init_val(input int i);
    return i[7:0] ^ i[14:7];
  endfunction
  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wait_ready(output int k);
    k = 0;
    while (req_ready !== 1'b1 && k < 40) begin
      @(negedge sys_clk);
      k++;
    end
  endtask
  // one request; called at a falling edge
  task automatic do_op(input logic wr, input logic [14:0] ad,
                       input logic [7:0] dt);
    int k;
    req_valid = 1'b1;
    req_write = wr;
    req_addr = ad;
    req_wdata = dt;
    wait_ready(k);
    @(negedge sys_clk);
    req_valid = 1'b0;
    k = 1;
    while (rsp_valid !== 1'b1 && k < 20) begin
      @(negedge sys_clk);
      k++;
    end
    check("latency", wr ? 16'h0003 : 16'h0004, 16'(k));
    if (wr) shadow[ad] = dt;
    else check("read data", {8'h00, shadow[ad]}, {8'h00, rsp_rdata});
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    resetn = 1'b0;
    supply_ok = 1'b1;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 15'h0000;
    req_wdata = 8'h00;
    err_count = 0;
    num_checks = 0;
    for (int i = 0; i < 32768; i++) shadow[i] = init_val(i);
    void'($urandom(32'hF0E0));
    repeat (16) @(negedge sys_clk);
    resetn = 1'b1;
    wait_ready(n);
    check("wake wait", 16'h0001,
      {15'h0, n >= ASP_RET_CYC + 3 && n < 40});
    for (int i = 0; i < 8; i++) begin
      do_op(i[2], {15{i[0]}} ^ {8'h00, i[1], 6'h00},
        {8{i[1]}} ^ 8'hA5);
    end
    $display("test corners done");
    for (int i = 0; i < 80; i++) begin
      a = 15'($urandom & ((i % 3 == 0) ? 32'h7FFF : 32'h0007));
      d = 8'($urandom);
      do_op(1'($urandom), a, d);
    end
    $display("test random done");
    supply_ok = 1'b0;
    repeat (8) @(negedge sys_clk);
    check("ready in drop", 16'h0000, {15'h0, req_ready});
    supply_ok = 1'b1;
    wait_ready(n);
    check("recovery wait", 16'h0001,
      {15'h0, n >= ASP_RET_CYC + 3 && n < 40});
    do_op(1'b0, 15'h0007, 8'h00);
    $display("test supply done");
    print_verdict();
  end
  initial begin
    #100000;
    err_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
